// ---- rtl/pqf_pkg.sv ----
// Package of constants for the parameter query response formatter
`default_nettype none
package pqf_pkg;
    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_RF_TUNING_FREQ   = 8'h10;
    localparam logic [7:0] ADDR_PARAMETER_QUERY  = 8'h32;
    localparam logic [7:0] ADDR_INFORMATION_QRY  = 8'h33;
    localparam logic [7:0] ADDR_SERIAL_OUT       = 8'h36;

    // ************************************************************
    // Command lengths in bytes, address byte included
    // ************************************************************
    localparam logic [3:0] LEN_RF_TUNING_FREQ    = 4'h8;
    localparam logic [3:0] LEN_QUERY             = 4'h2;
    localparam logic [3:0] LEN_SERIAL_OUT        = 4'h8;
    localparam logic [3:0] LEN_DEFAULT           = 4'h2;
    localparam int         RESP_BYTES            = 8;

    // ************************************************************
    // Selector codes
    // ************************************************************
    localparam logic [3:0] SEL_LAST_FREQ         = 4'h6;
    localparam logic [3:0] SEL_ATTEN             = 4'h7;
    localparam logic [3:0] SEL_CHAIN             = 4'h8;
    localparam logic [3:0] INFO_INTERFACE        = 4'h0;
    localparam logic [3:0] INFO_REVISION         = 4'h1;
    localparam logic [3:0] INFO_DATES            = 4'h2;

    // ************************************************************
    // Widths and field positions
    // ************************************************************
    localparam int FREQ_W     = 56;
    localparam int FREQ_MEAN_W = 48;
    localparam int CFG_W      = 10;
    localparam int CFG_UNUSED_BIT = 3;
    localparam int GAIN_W     = 16;
    localparam int GAIN_LSB   = 16;
    localparam int CAP_W      = 4;
    localparam int CAP_LSB    = 32;
    localparam int HI_WORD    = 32;
endpackage : pqf_pkg
`default_nettype wire

// ---- rtl/pqf_resp_mem.sv ----
// Small response memory holding the RF frequency value with registered read
`default_nettype none
module pqf_resp_mem #(
    parameter int DEPTH = 7,
    parameter int WIDTH = 56,
    parameter int AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ************************************************************
    // Write port
    // ************************************************************
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data from a register so the formatter sees a stable word
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule : pqf_resp_mem
`default_nettype wire

// ---- rtl/pqf_formatter.sv ----
// Query response formatter and byte command interpreter
// Functional notes
// R1 - A parameter response is eight bytes; selectors 0-6 are frequencies, 7 attenuators, 8 chain config.
// R2 - Frequencies fill bytes 0-6 unsigned in millihertz and byte 7 is zero.
// R3 - Attenuators are quarter-dB bytes: RF first in 5, RF second in 4, external IF in 2, final IF in 1 and 0.
// R4 - The chain configuration word sits in bytes 0-1 with the documented bit layout and bit 3 unused.
// R5 - The computed gain is a 16-bit sign-magnitude field in hundredths of a dB.
// R6 - An information response is eight bytes; selector 0 interface, 1 revisions, 2 dates.
// R7 - The interface response carries the serial number as a 32-bit value in bytes 0-3.
// R8 - Byte 4 of the interface response is the capability bitmap with its top four bits zero.
// R9 - The revision response has hardware revision in bytes 0-3 and firmware in 4-7 as float patterns.
// R10 - The date response has manufacture date low and calibration date high, day, month, then year.
// R11 - Each command is a byte buffer whose first byte is the register address and the rest its data.
// R12 - An Rf_tuning_frequency_register write is eight bytes: address then seven frequency bytes, most significant first.
// R13 - Written frequencies are in millihertz, the same unit as the query answers.
// R14 - Only the low six frequency bytes are meaningful and the upper bytes are expected zero.
// R15 - The information query is a write of a 4-bit selector in the low bits of its data byte.
// R16 - A serial-out write with zero data bytes shifts the pending eight response bytes out.
// R17 - Byte positions unused by a selector read as zero.
`default_nettype none
module pqf_formatter (
    input  wire logic        clk,
    input  wire logic        resetn,
    // Incoming command bytes, one per strobe
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic        cmd_frame_end,
    // Live state of the signal chain
    input  wire logic [55:0] if1_frequency,
    input  wire logic [55:0] if2_frequency,
    input  wire logic [55:0] if3_frequency,
    input  wire logic [55:0] lo1_frequency,
    input  wire logic [55:0] lo2_frequency,
    input  wire logic [55:0] lo3_frequency,
    input  wire logic [7:0]  rf_attenuator_first,
    input  wire logic [7:0]  rf_attenuator_second,
    input  wire logic [7:0]  external_if_attenuator,
    input  wire logic [7:0]  final_if_attenuator_first,
    input  wire logic [7:0]  final_if_attenuator_second,
    input  wire logic [9:0]  chain_configuration_word,
    input  wire logic [15:0] chain_computed_gain,
    input  wire logic [31:0] serial_number,
    input  wire logic [3:0]  capability_bits,
    input  wire logic [31:0] hardware_revision,
    input  wire logic [31:0] firmware_revision,
    input  wire logic [31:0] manufacture_date,
    input  wire logic [31:0] calibration_date,
    // Command results
    output logic [55:0] rf_tuning_frequency_register,
    output logic        rf_freq_write_pulse,
    output logic        other_cmd_pulse,
    output logic [7:0]  other_cmd_addr,
    output logic [55:0] other_cmd_data,
    // Response byte stream
    output logic        resp_valid,
    output logic [7:0]  resp_byte,
    output logic        resp_pending,
    output logic        busy
);
    typedef enum {PQF_IDLE, PQF_DATA, PQF_FETCH, PQF_FORMAT} pqf_state_t;

    // Parser state
    pqf_state_t  state_reg;
    logic [7:0]  addr_reg;
    logic [3:0]  count_reg;
    logic [3:0]  need_reg;
    logic [55:0] data_reg;
    logic [3:0]  sel_reg;
    logic        info_reg;
    logic [63:0] resp_word_reg;
    logic [2:0]  shift_idx_reg;
    logic        shifting_reg;
    // Store wiring
    logic [55:0] mem_rdata;
    logic [55:0] rf_freq_word;
    logic        mem_we;

    // Length of a command from its address byte
    // Other addresses take one data byte
    function automatic logic [3:0] pqf_cmd_len(input logic [7:0] addr);
        case (addr)
            pqf_pkg::ADDR_RF_TUNING_FREQ:  pqf_cmd_len = pqf_pkg::LEN_RF_TUNING_FREQ;
            pqf_pkg::ADDR_PARAMETER_QUERY: pqf_cmd_len = pqf_pkg::LEN_QUERY;
            pqf_pkg::ADDR_INFORMATION_QRY: pqf_cmd_len = pqf_pkg::LEN_QUERY;
            default:                       pqf_cmd_len = pqf_pkg::LEN_DEFAULT;
        endcase
    endfunction : pqf_cmd_len

    // Final data byte of the current frame
    function automatic logic pqf_last_byte(input logic [3:0] count, input logic [3:0] need);
        pqf_last_byte = (count == need - 4'h1);
    endfunction : pqf_last_byte

    // ************************************************************
    // Frequency store
    // ************************************************************
    // RF is kept in the memory; the remaining six track their inputs live
    // Reset writes zero so an early query is deterministic
    assign rf_freq_word = resetn ? {8'h00, data_reg[39:0], cmd_byte} : 56'h0; // R14
    assign mem_we = !resetn || ((state_reg == PQF_DATA) && cmd_valid && pqf_last_byte(count_reg, need_reg)
                    && (addr_reg == pqf_pkg::ADDR_RF_TUNING_FREQ));

    // Registered read: answer lags a write by a cycle
    pqf_resp_mem #(
        .DEPTH (1),
        .WIDTH (pqf_pkg::FREQ_W),
        .AW    (1)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (1'b0),
        .wdata (rf_freq_word),
        .raddr (1'b0),
        .rdata (mem_rdata)
    );

    // ************************************************************
    // Command parser
    // ************************************************************
    // Address first, then exactly the data bytes that address needs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= PQF_IDLE;
            addr_reg  <= 8'h00;
            count_reg <= 4'h0;
            need_reg  <= 4'h0;
            data_reg  <= 56'h0;
        end else begin
            case (state_reg)
                PQF_IDLE: begin
                    if (cmd_valid && !shifting_reg) begin
                        addr_reg  <= cmd_byte; // R11
                        need_reg  <= pqf_cmd_len(cmd_byte);
                        count_reg <= 4'h1;
                        data_reg  <= 56'h0;
                        // Serial-out has no data bytes here
                        if (cmd_byte == pqf_pkg::ADDR_SERIAL_OUT) begin
                            state_reg <= PQF_IDLE; // R16
                        end else begin
                            state_reg <= PQF_DATA;
                        end
                    end
                end
                PQF_DATA: begin
                    if (cmd_valid) begin
                        // Data bytes shift in most significant first
                        data_reg  <= {data_reg[47:0], cmd_byte}; // R12
                        count_reg <= count_reg + 4'h1;
                        if (pqf_last_byte(count_reg, need_reg)) begin
                            if (addr_reg == pqf_pkg::ADDR_PARAMETER_QUERY ||
                                addr_reg == pqf_pkg::ADDR_INFORMATION_QRY) begin
                                state_reg <= PQF_FETCH;
                            end else begin
                                state_reg <= PQF_IDLE;
                            end
                        end
                    end else if (cmd_frame_end) begin
                        state_reg <= PQF_IDLE; // Short frame is dropped rather than hanging
                    end
                end
                PQF_FETCH: begin
                    // Lets the stored word reach the read port
                    state_reg <= PQF_FORMAT;
                end
                PQF_FORMAT: begin
                    // Bytes in these two steps are ignored
                    state_reg <= PQF_IDLE;
                end
                default: begin
                    state_reg <= PQF_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Command outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rf_tuning_frequency_register <= 56'h0;
            rf_freq_write_pulse          <= 1'b0;
            other_cmd_pulse              <= 1'b0;
            other_cmd_addr               <= 8'h00;
            other_cmd_data               <= 56'h0;
            sel_reg                      <= 4'h0;
            info_reg                     <= 1'b0;
        end else begin
            // Pulses last one cycle
            rf_freq_write_pulse <= 1'b0;
            other_cmd_pulse     <= 1'b0;
            if (state_reg == PQF_DATA && cmd_valid && pqf_last_byte(count_reg, need_reg)) begin
                case (addr_reg)
                    pqf_pkg::ADDR_RF_TUNING_FREQ: begin
                        // Millihertz kept as received, top byte zero
                        rf_tuning_frequency_register <= {8'h00, data_reg[39:0], cmd_byte}; // R13
                        rf_freq_write_pulse          <= 1'b1;
                    end
                    // Queries only latch the selector
                    pqf_pkg::ADDR_PARAMETER_QUERY: begin
                        sel_reg  <= cmd_byte[3:0];
                        info_reg <= 1'b0;
                    end
                    pqf_pkg::ADDR_INFORMATION_QRY: begin
                        sel_reg  <= cmd_byte[3:0]; // R15
                        info_reg <= 1'b1;
                    end
                    default: begin
                        // Passed on whole to the rest of the unit
                        other_cmd_pulse <= 1'b1;
                        other_cmd_addr  <= addr_reg;
                        other_cmd_data  <= {data_reg[47:0], cmd_byte};
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Response formatting
    // ************************************************************
    // Every byte starts at zero so unused positions are deterministic
    always_ff @(posedge clk) begin
        if (!resetn) begin
            resp_word_reg <= 64'h0;
            resp_pending  <= 1'b0;
        end else if (state_reg == PQF_FORMAT) begin
            // A new query overwrites an unread answer
            resp_pending <= 1'b1;
            resp_word_reg <= 64'h0; // R17
            // Information or parameter answer
            if (info_reg) begin // R6
                case (sel_reg)
                    pqf_pkg::INFO_INTERFACE: resp_word_reg <= {24'h0, 4'h0, capability_bits, serial_number}; // R7 R8
                    pqf_pkg::INFO_REVISION:  resp_word_reg <= {firmware_revision, hardware_revision}; // R9
                    pqf_pkg::INFO_DATES:     resp_word_reg <= {calibration_date, manufacture_date}; // R10
                    default:                 resp_word_reg <= 64'h0;
                endcase
            end else begin // R1
                case (sel_reg)
                    4'h0: resp_word_reg <= {8'h00, mem_rdata}; // R2
                    4'h1: resp_word_reg <= {8'h00, if1_frequency};
                    4'h2: resp_word_reg <= {8'h00, if2_frequency};
                    4'h3: resp_word_reg <= {8'h00, if3_frequency};
                    4'h4: resp_word_reg <= {8'h00, lo1_frequency};
                    4'h5: resp_word_reg <= {8'h00, lo2_frequency};
                    pqf_pkg::SEL_LAST_FREQ: resp_word_reg <= {8'h00, lo3_frequency};
                    pqf_pkg::SEL_ATTEN: resp_word_reg <= {16'h0, rf_attenuator_first, rf_attenuator_second,
                                                          8'h00, external_if_attenuator,
                                                          final_if_attenuator_first,
                                                          final_if_attenuator_second}; // R3
                    pqf_pkg::SEL_CHAIN: resp_word_reg <= {32'h0, chain_computed_gain,
                                                          6'h00, chain_configuration_word[9:4], 1'b0,
                                                          chain_configuration_word[2:0]}; // R4 R5
                    // Codes above eight answer zero
                    default: resp_word_reg <= 64'h0;
                endcase
            end
        end else if (shifting_reg && shift_idx_reg == 3'h7) begin
            resp_pending <= 1'b0;
        end
    end

    // ************************************************************
    // Serial-out shifting
    // ************************************************************
    // Most significant byte first; one byte per cycle after the serial-out address
    // Bytes sent while shifting are dropped, so a burst is never cut
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shifting_reg  <= 1'b0;
            shift_idx_reg <= 3'h0;
            resp_valid    <= 1'b0;
            resp_byte     <= 8'h00;
        end else begin
            resp_valid <= 1'b0;
            if (!shifting_reg && state_reg == PQF_IDLE && cmd_valid &&
                cmd_byte == pqf_pkg::ADDR_SERIAL_OUT) begin
                shifting_reg  <= 1'b1; // R16
                shift_idx_reg <= 3'h0;
            end else if (shifting_reg) begin
                resp_valid    <= 1'b1;
                resp_byte     <= resp_word_reg[8'(63 - 8 * shift_idx_reg) -: 8];
                shift_idx_reg <= shift_idx_reg + 3'h1;
                // Pending drops on this same edge
                if (shift_idx_reg == 3'h7) begin
                    shifting_reg <= 1'b0;
                end
            end
        end
    end

    // Busy while a command is being taken or answered
    // Lags the state by one cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg != PQF_IDLE) || shifting_reg;
        end
    end
endmodule : pqf_formatter
`default_nettype wire

// ---- tb/pqf_host_model.sv ----
// Host model that sends command byte buffers to the formatter
`default_nettype none
module pqf_host_model (
    input  wire logic       clk,
    output var  logic       cmd_valid,
    output var  logic [7:0] cmd_byte,
    output var  logic       cmd_frame_end
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // Byte sender
    // ********************
    // Idle lines start low
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        cmd_frame_end = 1'b0;
    end
    // Address byte first, data MSB first; an idle byte line shows the inverse so stale data never looks valid
    task automatic send(input logic [63:0] frame, input int n, input int gap);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk);
            cmd_valid = 1'b1;
            cmd_byte = frame[8*i+:8];
            if (gap > 0) begin
                @(negedge clk);
                cmd_valid = 1'b0;
                cmd_byte = ~cmd_byte;
                repeat (gap - 1) @(negedge clk);
            end
        end
        if (gap == 0) begin
            @(negedge clk);
            cmd_valid = 1'b0;
            cmd_byte = ~cmd_byte;
        end
    endtask : send
    // Abandons a frame that was sent short
    task automatic abort();
        @(negedge clk);
        cmd_frame_end = 1'b1;
        @(negedge clk);
        cmd_frame_end = 1'b0;
    endtask : abort
endmodule : pqf_host_model
`default_nettype wire

// ---- tb/pqf_formatter_sva.sv ----
// Port checker for the response formatter
`default_nettype none
module pqf_formatter_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_byte,
    input wire logic [55:0] rf_tuning_frequency_register,
    input wire logic        rf_freq_write_pulse,
    input wire logic        other_cmd_pulse,
    input wire logic        resp_valid,
    input wire logic        resp_pending
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Response and shifting timing
    property p_burst_len; $rose(resp_valid) |-> resp_valid [*8] ##1 !resp_valid; endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst not eight bytes");
    property p_shift_go; cmd_valid && cmd_byte == pqf_pkg::ADDR_SERIAL_OUT && resp_pending && !resp_valid
        |-> ##2 resp_valid; endproperty
    a_shift_go: assert property (p_shift_go) else $error("shift did not start");
    property p_pend_hold; resp_pending && !resp_valid && !cmd_valid |=> resp_pending; endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending lost early");
    property p_need_pend; $rose(resp_valid) |-> resp_pending; endproperty
    a_need_pend: assert property (p_need_pend) else $error("burst without pending");
    // Frequency register only moves around a write; a late reset edge is excused
    property p_rf_stable; $changed(rf_tuning_frequency_register) && $past(resetn)
        |-> ($past(rf_freq_write_pulse) || rf_freq_write_pulse) or (##1 rf_freq_write_pulse); endproperty
    a_rf_stable: assert property (p_rf_stable) else $error("frequency moved alone");
    property p_top_zero; rf_tuning_frequency_register[55:48] == 8'h00; endproperty
    a_top_zero: assert property (p_top_zero) else $error("frequency top byte set");
    property p_other_one; other_cmd_pulse |=> !other_cmd_pulse; endproperty
    a_other_one: assert property (p_other_one) else $error("command pulse too long");
    property p_rf_one; rf_freq_write_pulse |-> !other_cmd_pulse ##1 !rf_freq_write_pulse; endproperty
    a_rf_one: assert property (p_rf_one) else $error("write pulse wrong");
    c_burst: cover property ($rose(resp_valid));
    c_rf: cover property (rf_freq_write_pulse);
    c_other: cover property (other_cmd_pulse);
endmodule : pqf_formatter_sva
bind pqf_formatter pqf_formatter_sva pqf_formatter_sva_inst (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .rf_tuning_frequency_register(rf_tuning_frequency_register),
    .rf_freq_write_pulse(rf_freq_write_pulse), .other_cmd_pulse(other_cmd_pulse), .resp_valid(resp_valid),
    .resp_pending(resp_pending));
`default_nettype wire

// ---- tb/pqf_formatter_tb.sv ----
// Self-checking testbench for the response formatter
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module pqf_formatter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // Signals and instances
    // ********************
    logic clk = 1'b0;
    logic resetn, cmd_valid, cmd_frame_end, rf_freq_write_pulse, other_cmd_pulse, resp_valid, resp_pending, busy;
    logic [7:0] cmd_byte, other_cmd_addr, resp_byte, b8;
    logic [55:0] if1_frequency, if2_frequency, if3_frequency, lo1_frequency, lo2_frequency, lo3_frequency;
    logic [7:0] rf_attenuator_first, rf_attenuator_second, external_if_attenuator;
    logic [7:0] final_if_attenuator_first, final_if_attenuator_second;
    logic [9:0] chain_configuration_word;
    logic [15:0] chain_computed_gain;
    logic [31:0] serial_number, hardware_revision, firmware_revision, manufacture_date, calibration_date;
    logic [3:0] capability_bits;
    logic [55:0] rf_tuning_frequency_register, other_cmd_data, rf_model;
    integer seed = 32'he9e8;
    int miscompares = 0;
    int compares = 0;
    always #2 clk = ~clk;
    pqf_formatter pqf_formatter_inst (.*);
    pqf_host_model pqf_host_model_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .cmd_frame_end(cmd_frame_end));
    // Expected eight-byte answer from the live inputs, with selector 0 taken from rf_model; unused bytes read zero
    function automatic logic [63:0] exp_resp(input logic [7:0] a, input logic [3:0] s);
        if (a == pqf_pkg::ADDR_INFORMATION_QRY) begin
            case (s)
                4'h0: return {28'h0, capability_bits, serial_number};
                4'h1: return {firmware_revision, hardware_revision};
                4'h2: return {calibration_date, manufacture_date};
                default: return 64'h0;
            endcase
        end
        case (s)
            4'h0: return {8'h00, rf_model};
            4'h1: return {8'h00, if1_frequency};
            4'h2: return {8'h00, if2_frequency};
            4'h3: return {8'h00, if3_frequency};
            4'h4: return {8'h00, lo1_frequency};
            4'h5: return {8'h00, lo2_frequency};
            4'h6: return {8'h00, lo3_frequency};
            4'h7: return {16'h0, rf_attenuator_first, rf_attenuator_second, 8'h00, external_if_attenuator,
                final_if_attenuator_first, final_if_attenuator_second};
            default: return {32'h0, chain_computed_gain, 6'h00, chain_configuration_word & 10'h3f7};
        endcase
    endfunction : exp_resp
    // New random chain state, applied between queries only
    task automatic rand_live();
        {if1_frequency, if2_frequency} = 112'({$random(seed), $random(seed), $random(seed), $random(seed)});
        {if3_frequency, lo1_frequency} = 112'({$random(seed), $random(seed), $random(seed), $random(seed)});
        {lo2_frequency, lo3_frequency} = 112'({$random(seed), $random(seed), $random(seed), $random(seed)});
        {rf_attenuator_first, rf_attenuator_second, external_if_attenuator, final_if_attenuator_first,
            final_if_attenuator_second} = 40'({$random(seed), $random(seed)});
        {chain_configuration_word, chain_computed_gain} = 26'($random(seed));
        {serial_number, capability_bits, hardware_revision} = 68'({$random(seed), $random(seed), $random(seed)});
        {firmware_revision, manufacture_date, calibration_date} = 96'({$random(seed), $random(seed), $random(seed)});
    endtask : rand_live
    // Query, then clock the answer out; byte 7 arrives first
    task automatic query(input logic [7:0] a, input logic [3:0] s, input int gap);
        logic [63:0] got;
        int cnt;
        got = 64'h0;
        cnt = 0;
        pqf_host_model_inst.send({48'h0, a, 4'h0, s}, 2, gap);
        for (int k = 0; k < 50 && resp_pending !== 1'b1; k++) @(negedge clk);
        `CHK({resp_pending, busy}, 2'h3)
        pqf_host_model_inst.send({56'h0, pqf_pkg::ADDR_SERIAL_OUT}, 1, 0);
        for (int k = 0; k < 40 && cnt < 8; k++) begin
            @(negedge clk);
            if (resp_valid === 1'b1) begin
                got = {got[55:0], resp_byte};
                cnt++;
            end
        end
        `CHK(got, exp_resp(a, s))
        @(negedge clk);
        `CHK({resp_valid, resp_pending}, 2'h0)
    endtask : query
    task automatic rf_write(input logic [47:0] f, input int gap);
        pqf_host_model_inst.send({pqf_pkg::ADDR_RF_TUNING_FREQ, 8'h00, f}, 8, gap);
        rf_model = {8'h00, f};
    endtask : rf_write
    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    // ********************
    // Main sequence
    // ********************
    initial begin
        resetn = 1'b0;
        rf_model = 56'h0;
        rand_live();
        repeat (5) @(negedge clk);
        `CHK({resp_valid, resp_pending, busy, rf_freq_write_pulse, other_cmd_pulse}, 5'h00)
        resetn = 1'b1;
        rf_write(48'h0574fbde6000, 0);
        for (int r = 0; r < 4; r++) begin
            query(pqf_pkg::ADDR_PARAMETER_QUERY, 4'h0, r);
            `CHK(rf_tuning_frequency_register, rf_model)
            rand_live();
            for (int s = 1; s <= 8; s++) query(pqf_pkg::ADDR_PARAMETER_QUERY, 4'(s), r % 2);
            for (int s = 0; s <= 3; s++) query(pqf_pkg::ADDR_INFORMATION_QRY, 4'(s), r);
            rf_write(48'({$random(seed), $random(seed)}), r);
        end
        // Generic two-byte command lands on the pass-through outputs
        b8 = 8'($random(seed));
        pqf_host_model_inst.send({48'h0, 8'h15, b8}, 2, 1);
        for (int k = 0; k < 10 && other_cmd_addr !== 8'h15; k++) @(negedge clk);
        `CHK({other_cmd_addr, other_cmd_data}, {8'h15, 48'h0, b8})
        // A short write is abandoned and must not touch the stored frequency
        pqf_host_model_inst.send({32'h0, pqf_pkg::ADDR_RF_TUNING_FREQ, 24'hffffff}, 4, 0);
        pqf_host_model_inst.abort();
        query(pqf_pkg::ADDR_PARAMETER_QUERY, 4'h0, 0);
        `CHK(rf_tuning_frequency_register, rf_model)
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        `CHK(rf_tuning_frequency_register, 56'h0)
        rf_model = 56'h0;
        query(pqf_pkg::ADDR_PARAMETER_QUERY, 4'h0, 0);
        report_and_stop();
    end
    // Watchdog well beyond the roughly one thousand cycles the sequence needs
    initial begin
        #(20000 * 4);
        miscompares++;
        report_and_stop();
    end
endmodule : pqf_formatter_tb
`default_nettype wire
